// ===== design/qpc_top.sv
// Quadrature position control with AHB-Lite register access
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`default_nettype none
// What this block does
// [R1] Enable bit 15 runs the counters
// [R2] Enable low halts counters, registers stay accessible
// [R3] Bit 14 reads as zero
// [R4] Idle stop set suspends during device idle
// [R5] Idle stop clear keeps counting in idle
// [R6] Three-bit init mode field; 111 reserved
// [R7] Code 110 selects modulo counting
// [R8] Code 101 resets on compare equality
// [R9] Code 100 loads on second index after home
// [R10] Code 000 index leaves counter alone
// [R11] Phase B match level chosen by bit 9
// [R12] Phase A match level chosen by bit 8
// [R13] Code 011 loads on first index after home
// [R14] Code 010 loads on next index
// [R15] Code 001 resets on every index
// [R16] Index event needs index and matching phases
module qpc_top
    import qpc_pkg::*;
#(
    parameter int PW = 32
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    // AHB-Lite slave
    input  wire logic          hsel_i,
    input  wire logic [31:0]   haddr_i,
    input  wire logic [1:0]    htrans_i,
    input  wire logic          hwrite_i,
    input  wire logic [2:0]    hsize_i,
    input  wire logic [31:0]   hwdata_i,
    input  wire logic          hready_i,
    output logic      [31:0]   hrdata_o,
    output logic               hreadyout_o,
    output logic               hresp_o,
    // Device power state
    input  wire logic          device_idle_i,
    // Encoder pins
    input  wire logic          phase_a_input_i,
    input  wire logic          phase_b_input_i,
    input  wire logic          index_i,
    input  wire logic          home_i,
    // Position output
    output logic      [PW-1:0] position_o
);
    // =========================================================
    // Storage
    // Software-visible registers
    logic [15:0]   ctrl_ff;       // Control register
    logic [PW-1:0] init_ff;       // Initialization value register
    logic [PW-1:0] cmp_ff;        // Equality compare register
    logic [PW-1:0] mod_ff;        // Modulo limit register
    logic [PW-1:0] pos_ff;        // Position counter

    // Bus interface state
    logic [31:0]   rdata_ff;      // Read data register
    logic          wr_pend_ff;    // Write data phase pending
    logic [7:0]    wr_addr_ff;    // Latched write address

    // Index sequencing flags
    logic          home_seen_ff;  // Home event armed
    logic          first_done_ff; // First index after home seen
    logic          next_armed_ff; // Next-index load still pending

    // Edge history and status
    logic          idx_q_ff;      // Previous index match
    logic          home_q_ff;     // Previous home level
    logic          sidle_ff;      // Idle stop status

    // =========================================================
    // Synchronise encoder pins
    // All four pins pass two flops before any logic reads them
    qpc_enc_t enc_raw;
    qpc_enc_t enc;
    assign enc_raw = '{phase_a: phase_a_input_i, phase_b: phase_b_input_i,
                       index: index_i, home: home_i};
    qpc_sync #(.W(4)) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .async_i (enc_raw),
        .sync_o  (enc)
    );

    // =========================================================
    // Quadrature decode
    // A double-phase jump is dropped, not counted
    logic step;  // One count step
    logic up;    // Direction
    qpc_decode u_dec (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .phase_a_i (enc.phase_a),
        .phase_b_i (enc.phase_b),
        .step_o    (step),
        .up_o      (up)
    );

    // =========================================================
    // Control field view
    // Field positions are package constants
    qpc_ctrl_t ctl;
    assign ctl = '{counter_enable_bit:  ctrl_ff[EN_BIT],
                   idle_stop_bit:       ctrl_ff[SIDL_BIT],
                   position_init_mode:  ctrl_ff[MODE_HI:MODE_LO],
                   index_match_phase_b: ctrl_ff[IMB_BIT],
                   index_match_phase_a: ctrl_ff[IMA_BIT]};

    // Running: enabled and not stopped by idle
    // Idle stop only acts while the device idles
    wire run = ctl.counter_enable_bit                      // R1 R2
             & ~(ctl.idle_stop_bit & device_idle_i);       // R4 R5

    // Index match on level and both phases
    // A level match; the event is its rising edge
    wire idx_match = enc.index                                   // R16
                   & (enc.phase_b == ctl.index_match_phase_b)    // R11
                   & (enc.phase_a == ctl.index_match_phase_a);   // R12
    // Rising edges of the index match and of home
    wire idx_evt   = idx_match & ~idx_q_ff;
    wire home_evt  = enc.home & ~home_q_ff;

    // Index action per mode
    // Code 111 is reserved and acts like 000
    wire [2:0] md     = ctl.position_init_mode;                     // R6
    wire idx_reset    = idx_evt & (md == MODE_EVERY);               // R15
    wire idx_load_nxt = idx_evt & (md == MODE_NEXT) & next_armed_ff;// R14
    wire idx_load_1st = idx_evt & (md == MODE_FIRST)
                      & home_seen_ff;                               // R13
    wire idx_load_2nd = idx_evt & (md == MODE_SECOND)
                      & home_seen_ff & first_done_ff;               // R9
    wire idx_load     = idx_load_nxt | idx_load_1st | idx_load_2nd;
    // Compare reset is tested every cycle while running
    wire cmp_reset    = (md == MODE_CMP) & (pos_ff == cmp_ff);      // R8
    wire is_modulo    = (md == MODE_MODULO);                        // R7

    // Hardware sets of the sequencing flags win over a
    // control write that clears them in the same cycle
    wire home_set     = run & home_evt;
    wire first_set    = run & idx_evt & home_seen_ff & ~home_evt
                      & ~idx_load_1st & ~idx_load_2nd;

    // Step with optional modulo wrap
    // Modulo counts run from zero up to the limit
    logic [PW-1:0] stepped;
    always_comb begin
        stepped = pos_ff;
        // Up wraps from the limit to zero
        if (up) begin
            if (is_modulo && pos_ff == mod_ff) begin
                stepped = '0;                                       // R7
            end else begin
                stepped = pos_ff + 1'b1;
            end
        end else begin
            // Down wraps from zero to the limit
            if (is_modulo && pos_ff == '0) begin
                stepped = mod_ff;                                   // R7
            end else begin
                stepped = pos_ff - 1'b1;
            end
        end
    end

    // Next position; mode 000 and 111 take no index action
    // A reset beats a load, and a load beats a step
    logic [PW-1:0] nxt_pos;
    always_comb begin
        nxt_pos = pos_ff;
        if (run) begin                                              // R1 R2
            if (idx_reset || cmp_reset) begin
                nxt_pos = '0;                                       // R8
            end else if (idx_load) begin
                nxt_pos = init_ff;                                  // R9
            end else if (step) begin
                nxt_pos = stepped;                                  // R10
            end
        end
    end

    // =========================================================
    // AHB-Lite decode
    // An address phase is taken when selected, ready and active
    wire        addr_ok  = hsel_i & hready_i & htrans_i[1];
    wire        wr_req   = addr_ok & hwrite_i;
    wire        rd_req   = addr_ok & ~hwrite_i;
    wire [7:0]  a_ofs    = haddr_i[7:0];

    // One write strobe per register in the data phase
    wire        w_ctrl   = wr_pend_ff & (wr_addr_ff == CTRL_OFS);
    wire        w_init   = wr_pend_ff & (wr_addr_ff == INIT_OFS);
    wire        w_cmp    = wr_pend_ff & (wr_addr_ff == CMP_OFS);
    wire        w_mod    = wr_pend_ff & (wr_addr_ff == MOD_OFS);
    wire        w_pos    = wr_pend_ff & (wr_addr_ff == POS_OFS);

    // Read mux; bit 14 and other unused bits read zero
    // Status word: home armed, idle stopped, running
    // Unmapped offsets read as zero
    logic [31:0] rmux;
    always_comb begin
        case (a_ofs)
            CTRL_OFS: rmux = {16'h0000, ctrl_ff & CTRL_MASK};       // R3
            INIT_OFS: rmux = 32'(init_ff);
            CMP_OFS:  rmux = 32'(cmp_ff);
            MOD_OFS:  rmux = 32'(mod_ff);
            POS_OFS:  rmux = 32'(pos_ff);
            STAT_OFS: rmux = {29'h0, home_seen_ff, sidle_ff, run};
            default:  rmux = 32'h0000_0000;
        endcase
    end

    // =========================================================
    // Bus registers (writes always accepted)
    // The write address follows the bus; read only while pending
    // Read data is captured only when a read is taken
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= wr_req;
            wr_addr_ff <= a_ofs;
            if (rd_req) begin
                rdata_ff <= rmux;
            end
        end
    end

    // Software registers stay writable while halted
    // Narrow registers take the low bits of the data word
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= CTRL_RST;
            init_ff <= '0;
            cmp_ff  <= '0;
            mod_ff  <= '0;
        end else begin
            if (w_ctrl) ctrl_ff <= hwdata_i[15:0] & CTRL_MASK;      // R2 R3
            if (w_init) init_ff <= hwdata_i[PW-1:0];
            if (w_cmp)  cmp_ff  <= hwdata_i[PW-1:0];
            if (w_mod)  mod_ff  <= hwdata_i[PW-1:0];
        end
    end

    // =========================================================
    // Position counter and index sequencing
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            // Counter, flags and edge history start idle
            pos_ff        <= POS_RST;
            home_seen_ff  <= 1'b0;
            first_done_ff <= 1'b0;
            next_armed_ff <= 1'b1;
            idx_q_ff      <= 1'b0;
            home_q_ff     <= 1'b0;
            sidle_ff      <= 1'b0;
        end else begin
            // Edge history and idle status
            idx_q_ff  <= idx_match;
            home_q_ff <= enc.home;
            sidle_ff  <= ctl.idle_stop_bit & device_idle_i;         // R4
            // A bus write to the position wins over counting
            pos_ff    <= w_pos ? hwdata_i[PW-1:0] : nxt_pos;
            // Control write rearms the one-shot sequences
            if (w_ctrl) begin
                // Clear, unless hardware sets in the same cycle
                home_seen_ff  <= home_set;
                first_done_ff <= first_set;
                next_armed_ff <= 1'b1;
            end else if (run) begin
                // Home arms both after-home modes
                if (home_evt) begin
                    home_seen_ff  <= 1'b1;
                    first_done_ff <= 1'b0;
                end else if (idx_load_1st || idx_load_2nd) begin
                    // A load disarms until the next home
                    home_seen_ff  <= 1'b0;                          // R13
                    first_done_ff <= 1'b0;
                end else if (idx_evt && home_seen_ff) begin
                    // First index after home is noted
                    first_done_ff <= 1'b1;                          // R9
                end
                // Next-index loads once per control write
                if (idx_load_nxt) begin
                    next_armed_ff <= 1'b0;                          // R14
                end
            end
        end
    end

    // =========================================================
    // Outputs
    // Zero wait states and an OKAY answer, always
    // Read data and position come straight from flops
    assign hrdata_o    = rdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign position_o  = pos_ff;
endmodule : qpc_top
`default_nettype wire

// ===== design/qpc_pkg.sv
// Package of constants and types for the quadrature position control block
`default_nettype none
package qpc_pkg;
    // =========================================================
    // Register map
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] INIT_OFS     = 8'h04;
    localparam logic [7:0] CMP_OFS      = 8'h08;
    localparam logic [7:0] MOD_OFS      = 8'h0c;
    localparam logic [7:0] POS_OFS      = 8'h10;
    localparam logic [7:0] STAT_OFS     = 8'h14;
    // =========================================================
    // Control register fields
    localparam int         EN_BIT       = 15;
    localparam int         SIDL_BIT     = 13;
    localparam int         MODE_HI      = 12;
    localparam int         MODE_LO      = 10;
    localparam int         IMB_BIT      = 9;
    localparam int         IMA_BIT      = 8;
    // Writable bits of the control register
    localparam logic [15:0] CTRL_MASK   = 16'hbf00;
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [31:0] POS_RST     = 32'h0000_0000;
    // =========================================================
    // Initialization modes
    localparam logic [2:0] MODE_NONE    = 3'h0;
    localparam logic [2:0] MODE_EVERY   = 3'h1;
    localparam logic [2:0] MODE_NEXT    = 3'h2;
    localparam logic [2:0] MODE_FIRST   = 3'h3;
    localparam logic [2:0] MODE_SECOND  = 3'h4;
    localparam logic [2:0] MODE_CMP     = 3'h5;
    localparam logic [2:0] MODE_MODULO  = 3'h6;
    // =========================================================
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    // Control fields as a carrier
    typedef struct packed {
        logic       counter_enable_bit;
        logic       idle_stop_bit;
        logic [2:0] position_init_mode;
        logic       index_match_phase_b;
        logic       index_match_phase_a;
    } qpc_ctrl_t;
    // Synchronised encoder levels
    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic index;
        logic home;
    } qpc_enc_t;
endpackage : qpc_pkg
`default_nettype wire

// ===== design/qpc_sync.sv
// Two flip-flop synchroniser for the encoder pins
`default_nettype none
module qpc_sync
    import qpc_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;  // First stage, read only by second
    logic [W-1:0] sync_ff;  // Second stage

    // =========================================================
    // Two stages per bit
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule : qpc_sync
`default_nettype wire

// ===== design/qpc_decode.sv
// Quadrature phase decoder producing count pulses and direction
`default_nettype none
module qpc_decode
    import qpc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Synchronised phases
    input  wire logic phase_a_i,
    input  wire logic phase_b_i,
    // Count outputs
    output logic      step_o,
    output logic      up_o
);
    logic a_q_ff;  // Previous phase A
    logic b_q_ff;  // Previous phase B

    // =========================================================
    // Remember last phase levels
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            a_q_ff <= 1'b0;
            b_q_ff <= 1'b0;
        end else begin
            a_q_ff <= phase_a_i;
            b_q_ff <= phase_b_i;
        end
    end
    // A single-phase change is one step; both at once is ignored
    assign step_o = (phase_a_i ^ a_q_ff) ^ (phase_b_i ^ b_q_ff);
    // A leads B for counting up
    assign up_o   = phase_a_i ^ b_q_ff;
endmodule : qpc_decode
`default_nettype wire

// ===== bench/qpc_properties.sv
// Port checker for the quadrature position control block
`default_nettype none
module qpc_props
    import qpc_pkg::*;
#(
    parameter int PW = 32
) (
    // Clock and reset
    input wire logic          clk_i,
    input wire logic          rst_b_i,
    // Bus
    input wire logic          hsel_i,
    input wire logic [31:0]   haddr_i,
    input wire logic [1:0]    htrans_i,
    input wire logic          hwrite_i,
    input wire logic [31:0]   hwdata_i,
    input wire logic          hready_i,
    input wire logic [31:0]   hrdata_o,
    input wire logic          hreadyout_o,
    input wire logic          hresp_o,
    // Device state and encoder
    input wire logic          device_idle_i,
    input wire logic          phase_a_input_i,
    input wire logic          phase_b_input_i,
    input wire logic [PW-1:0] position_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====
    // Data phase tracking and control shadow
    logic        take, pos_wr, mv, hold;
    logic        wr_ff, rd_ff;
    logic [7:0]  adr_ff;
    logic [15:0] ctl_ff;
    logic [2:0]  md;
    logic [5:0]  sa_ff, sb_ff;
    assign take   = hsel_i & hready_i & htrans_i[1];
    assign pos_wr = wr_ff & (adr_ff == POS_OFS);
    assign md     = ctl_ff[MODE_HI:MODE_LO];
    assign hold   = ctl_ff[SIDL_BIT] & device_idle_i;
    // Any phase change within the last few samples
    assign mv = |{sa_ff[5:1] ^ sa_ff[4:0], sb_ff[5:1] ^ sb_ff[4:0]};
    // Shadow follows control writes at the data phase edge
    always_ff @(posedge clk_i) begin
        wr_ff  <= rst_b_i & take & hwrite_i;
        rd_ff  <= rst_b_i & take & ~hwrite_i;
        adr_ff <= haddr_i[7:0];
        sa_ff  <= {sa_ff[4:0], phase_a_input_i};
        sb_ff  <= {sb_ff[4:0], phase_b_input_i};
        if (!rst_b_i)
            ctl_ff <= CTRL_RST;
        else if (wr_ff && adr_ff == CTRL_OFS)
            ctl_ff <= hwdata_i[15:0] & CTRL_MASK;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ====
    // Properties
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus slave not ready or not okay");
    a_ctrl_readback: assert property (rd_ff && adr_ff == CTRL_OFS
        |-> hrdata_o == {16'h0, $past(ctl_ff)})
        else $error("control read back wrong");
    a_pos_readback: assert property (rd_ff && adr_ff == POS_OFS
        |-> hrdata_o == $past(position_o))
        else $error("position read back wrong");
    a_rdata_holds: assert property (
        !(take && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data moved without a read");
    a_reset_clears: assert property (disable iff (1'b0)
        !rst_b_i |=> position_o == '0 && hrdata_o == 32'h0)
        else $error("reset did not clear outputs");
    a_halt_freezes: assert property (
        !ctl_ff[EN_BIT] && !pos_wr |=> $stable(position_o))
        else $error("position moved while disabled");
    a_idle_freezes: assert property (
        hold && !pos_wr |=> $stable(position_o))
        else $error("position moved in idle with stop set");
    a_step_single: assert property (
        md == MODE_NONE && !pos_wr |=>
        $stable(position_o) || position_o == $past(position_o) + 1'b1 ||
        position_o + 1'b1 == $past(position_o))
        else $error("position jumped in plain mode");
    a_move_cause: assert property (
        md == MODE_NONE && !pos_wr ##1 !$stable(position_o) |-> mv)
        else $error("position moved without a phase change");
    // Main scenarios reached
    c_moved: cover property (ctl_ff[EN_BIT] && !$stable(position_o));
    c_idle: cover property (hold && ctl_ff[EN_BIT]);
    c_ctrl_read: cover property (rd_ff && adr_ff == CTRL_OFS);
endmodule : qpc_props
bind qpc_top qpc_props #(.PW(PW)) u_props (.clk_i, .rst_b_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .device_idle_i, .phase_a_input_i,
    .phase_b_input_i, .position_o);
`default_nettype wire

// ===== bench/qpc_enc_model.sv
// Behavioural incremental encoder with index and home marks
`default_nettype none
module qpc_enc_model (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Commands from the bench
    input  wire logic move_i,
    input  wire logic up_i,
    input  wire logic mark_i,
    input  wire logic home_req_i,
    // Encoder pins
    output logic      phase_a_o,
    output logic      phase_b_o,
    output logic      index_o,
    output logic      home_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] pos_ff;  // Quarter cycle state
    // One state per move, so only one phase changes at a time
    always_ff @(posedge clk_i) begin
        if (!rst_b_i)
            pos_ff <= 2'h0;
        else if (move_i)
            pos_ff <= up_i ? pos_ff + 2'h1 : pos_ff - 2'h1;
        index_o <= mark_i;
        home_o  <= home_req_i;
    end
    // Phase A leads phase B when moving up
    assign phase_a_o = pos_ff[1] ^ pos_ff[0];
    assign phase_b_o = pos_ff[1];
endmodule : qpc_enc_model
`default_nettype wire

// ===== bench/qpc_top_tb_top.sv
// Self-checking bench for the quadrature position control block
`default_nettype none
module qpc_top_tb_top
    import qpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ====
    // Stimulus and observation
    logic        clk_i = 1'b0, rst_b_i = 1'b0, device_idle_i = 1'b0;
    logic        hsel_i = 1'b0, hwrite_i = 1'b0, hreadyout_o, hresp_o;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, pos, r, ep;
    logic [1:0]  htrans_i = 2'h0, st = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic        pa, pb, idx, home, move = 1'b0, up = 1'b1;
    logic        mark = 1'b0, home_req = 1'b0, rd_phase = 1'b0;
    logic [31:0] exp_q[$];
    int          errors = 0, tests_run = 0, cyc = 0, n;
    always #12.5 clk_i = ~clk_i;
    qpc_top #(.PW(32)) dut (.clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .device_idle_i, .phase_a_input_i(pa),
        .phase_b_input_i(pb), .index_i(idx), .home_i(home), .position_o(pos));
    qpc_enc_model enc (.clk_i, .rst_b_i, .move_i(move), .up_i(up),
        .mark_i(mark), .home_req_i(home_req), .phase_a_o(pa),
        .phase_b_o(pb), .index_o(idx), .home_o(home));
    // ====
    // Comparison and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // ====
    // Bus master: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= HTRANS_NONSEQ;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i   <= 1'b0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    // Note the expected word, then read it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Encoder moves with random spacing
    task automatic steps(input int k, input logic dir);
        repeat (k) begin
            up   <= dir;
            move <= 1'b1;
            st = dir ? st + 2'h1 : st - 2'h1;
            @(posedge clk_i);
            move <= 1'b0;
            repeat ($urandom_range(3, 1)) @(posedge clk_i);
        end
        repeat (5) @(posedge clk_i);
    endtask : steps
    // Index mark or home mark
    task automatic pulse(input logic hm);
        mark     <= !hm;
        home_req <= hm;
        repeat (3) @(posedge clk_i);
        mark     <= 1'b0;
        home_req <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask : pulse
    function automatic logic [31:0] ctl(input logic en, sidl,
        input logic [2:0] m, input logic b, a);
        return {16'h0, en, 1'b0, sidl, m, b, a, 8'h0};
    endfunction : ctl
    // Read data checker and hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rd_phase && hreadyout_o === 1'b1)
            chk(hrdata_o, exp_q.pop_front());
        if (hreadyout_o === 1'b1)
            rd_phase <= hsel_i && htrans_i[1] && !hwrite_i;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // ====
    // Main sequence
    initial begin
        void'($urandom(32'hb657));
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(CTRL_OFS, 32'h0);
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 32'h0);
        wr(CTRL_OFS, 32'hffff_ffff);
        rd(CTRL_OFS, 32'h0000_bf00);
        wr(CTRL_OFS, ctl(1'b0, 1'b0, MODE_NONE, 1'b0, 1'b0));
        r = $urandom;
        wr(POS_OFS, r);
        steps(4, 1'b1);
        rd(POS_OFS, r);
        wr(CTRL_OFS, ctl(1'b1, 1'b0, MODE_NONE, st[1], ^st));
        n = $urandom_range(6, 2);
        steps(n, 1'b1);
        steps(2, 1'b0);
        pulse(1'b0);
        rd(POS_OFS, r + n - 2);
        wr(CTRL_OFS, ctl(1'b1, 1'b1, MODE_NONE, 1'b0, 1'b0));
        device_idle_i <= 1'b1;
        steps(3, 1'b1);
        rd(POS_OFS, r + n - 2);
        rd(STAT_OFS, 32'h2);
        device_idle_i <= 1'b0;
        wr(CTRL_OFS, ctl(1'b1, 1'b0, MODE_NONE, 1'b0, 1'b0));
        device_idle_i <= 1'b1;
        wr(POS_OFS, 32'h10);
        steps(3, 1'b1);
        rd(POS_OFS, 32'h13);
        device_idle_i <= 1'b0;
        // Index modes; a full turn between marks keeps the phases matched
        for (int m = 1; m <= 4; m++) begin
            r  = $urandom;
            ep = $urandom;
            wr(INIT_OFS, r);
            wr(POS_OFS, ep);
            wr(CTRL_OFS, ctl(1'b1, 1'b0, m[2:0], st[1], ^st));
            if (m >= 3)
                pulse(1'b1);
            pulse(1'b0);
            rd(POS_OFS, m == 1 ? 32'h0 : m == 4 ? ep : r);
            steps(4, 1'b1);
            pulse(1'b0);
            rd(POS_OFS, m == 1 ? 32'h0 : m == 4 ? r : r + 4);
        end
        // One phase off the chosen level blocks the index
        for (int k = 0; k < 4; k++) begin
            wr(POS_OFS, 32'h55);
            wr(CTRL_OFS, ctl(1'b1, 1'b0, MODE_EVERY, st[1] ^ k[0],
                             ^st ^ ~k[0]));
            pulse(1'b0);
            rd(POS_OFS, 32'h55);
            wr(CTRL_OFS, ctl(1'b1, 1'b0, MODE_EVERY, st[1], ^st));
            pulse(1'b0);
            rd(POS_OFS, 32'h0);
            steps(1, 1'b1);
        end
        wr(CMP_OFS, 32'h3);
        wr(POS_OFS, 32'h0);
        wr(CTRL_OFS, ctl(1'b1, 1'b0, MODE_CMP, 1'b0, 1'b0));
        steps(3, 1'b1);
        rd(POS_OFS, 32'h0);
        wr(MOD_OFS, 32'h3);
        wr(CTRL_OFS, ctl(1'b1, 1'b0, MODE_MODULO, 1'b0, 1'b0));
        steps(5, 1'b1);
        rd(POS_OFS, 32'h1);
        // Reset in mid-run
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(POS_OFS, 32'h0);
        repeat (3) @(posedge clk_i);
        give_verdict();
    end
endmodule : qpc_top_tb_top
`default_nettype wire
